// file: rtl/dbl_defines.vh
// Constants for the DMA burst / link-test control register block.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef DBL_DEFINES_VH
`define DBL_DEFINES_VH

// ************************************************************
// Register map (Avalon word addresses, byte address = 4 * index)
// ************************************************************
`define DBL_ADDR_W 4
`define DBL_IDX_CTRL 4'h0
`define DBL_IDX_MODE 4'h1
`define DBL_IDX_BASE 4'h2

// ************************************************************
// Field positions of the control register
// ************************************************************
`define DBL_BIT_UNLOCK 7
`define DBL_BIT_RSVD6 6
`define DBL_BIT_LINK 5
`define DBL_BURST_HI 1
`define DBL_BURST_LO 0
`define DBL_CTRL_RESET 8'h80
`define DBL_CTRL_WMASK 8'hA3

// ************************************************************
// Host I/O offset that steps the base select
// ************************************************************
`define DBL_IO_OFS_W 5
`define DBL_IO_STEP_OFS 5'h12

// ************************************************************
// Interface modes on the mode input
// ************************************************************
`define DBL_MODE_W 2
`define DBL_MODE_PCCARD 2'h0
`define DBL_MODE_ISA_JL 2'h1
`define DBL_MODE_ISA_JP 2'h2
`define DBL_MODE_GP 2'h3

// ************************************************************
// Burst field decode values
// ************************************************************
`define DBL_BURST_CODE_1 2'h0
`define DBL_BURST_CODE_4 2'h1
`define DBL_BURST_CODE_18 2'h2
`define DBL_BURST_CODE_12 2'h3
`define DBL_CNT_W 5
`define DBL_CNT_1 5'h01
`define DBL_CNT_4 5'h04
`define DBL_CNT_18 5'h12
`define DBL_CNT_12 5'h0C

`define DBL_SEL_W 3
`define DBL_SEL_RESET 3'h0

`endif

// file: rtl/dbl_burst_decode.v
// Decoder from the two-bit burst field to a maximum transfer count.
// Assumes a purely combinational context; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "dbl_defines.vh"

module dbl_burst_decode (
    input wire [1:0] burst_field,
    input wire [`DBL_MODE_W-1:0] if_mode,
    output reg [`DBL_CNT_W-1:0] burst_count
);
    // ************************************************************
    // Field decode
    // ************************************************************
    // Card mode always gets single transfers; the field has no effect there
    always @* begin
        if (if_mode == `DBL_MODE_PCCARD) begin
            burst_count = `DBL_CNT_1;
        end else begin
            case (burst_field)
                `DBL_BURST_CODE_1: burst_count = `DBL_CNT_1;
                `DBL_BURST_CODE_4: burst_count = `DBL_CNT_4;
                `DBL_BURST_CODE_18: burst_count = `DBL_CNT_18;
                `DBL_BURST_CODE_12: burst_count = `DBL_CNT_12;
                default: burst_count = `DBL_CNT_1;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rtl/dbl_ctrl.v
// DMA burst / link-test / base-unlock control register with Avalon-MM slave.
// Assumes a host I/O decoder that pulses io_rd with its offset, and
// a mode input from the strap logic, both synchronous to mclk.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dbl_defines.vh"

module dbl_ctrl (
    input wire mclk,
    input wire srst,
    input wire [`DBL_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [1:0] avs_response,
    input wire [`DBL_MODE_W-1:0] if_mode,
    input wire io_rd,
    input wire [`DBL_IO_OFS_W-1:0] io_offset,
    output reg [`DBL_SEL_W-1:0] io_base_select,
    output reg link_test_run,
    output reg [`DBL_CNT_W-1:0] dma_burst_count
);
    // ************************************************************
    // Storage
    // ************************************************************
    reg [7:0] dma_burst_link_control_q; // Control register
    reg [7:0] dma_burst_link_control_d; // Its next value
    reg [`DBL_SEL_W-1:0] sel_d; // Next base select
    reg ack_q; // Answer pulse, drops waitrequest
    wire [`DBL_CNT_W-1:0] burst_dec; // Decoded burst count
    wire access; // Read or write pending
    wire wr_fire; // Write takes effect this edge
    wire step_hit; // Qualified stepping read

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // One wait cycle per access gives a registered read path
    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_q;
    assign wr_fire = avs_write & ack_q;

    // Ack toggles so back-to-back requests each wait one cycle
    always @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access & ~ack_q;
        end
    end

    // ************************************************************
    // Control register next value
    // ************************************************************
    // Only byte lane 0 carries data; reserved bits are forced low
    always @* begin
        dma_burst_link_control_d = dma_burst_link_control_q;
        if (wr_fire && avs_address == `DBL_IDX_CTRL && avs_byteenable[0]) begin
            dma_burst_link_control_d = avs_writedata[7:0] & `DBL_CTRL_WMASK;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            dma_burst_link_control_q <= `DBL_CTRL_RESET;
        end else begin
            dma_burst_link_control_q <= dma_burst_link_control_d;
        end
    end

    // ************************************************************
    // Base select stepping
    // ************************************************************
    // Wraps through all eight bases; software walks until it finds itself
    assign step_hit = io_rd && io_offset == `DBL_IO_STEP_OFS
        && dma_burst_link_control_q[`DBL_BIT_UNLOCK]
        && if_mode == `DBL_MODE_ISA_JL;

    always @* begin
        sel_d = io_base_select;
        if (step_hit) begin
            sel_d = io_base_select + 3'h1;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            io_base_select <= `DBL_SEL_RESET;
        end else begin
            io_base_select <= sel_d;
        end
    end

    // ************************************************************
    // Outputs to transceiver and DMA engine
    // ************************************************************
    dbl_burst_decode u_dec (
        .burst_field(dma_burst_link_control_q[`DBL_BURST_HI:`DBL_BURST_LO]),
        .if_mode(if_mode),
        .burst_count(burst_dec)
    );

    // Registered so downstream sees no decode glitches
    always @(posedge mclk) begin
        if (srst) begin
            link_test_run <= 1'b1;
            dma_burst_count <= `DBL_CNT_1;
        end else begin
            link_test_run <= ~dma_burst_link_control_q[`DBL_BIT_LINK];
            dma_burst_count <= burst_dec;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped addresses read zero with SLVERR response
    always @(posedge mclk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else if (access & ~ack_q) begin
            avs_response <= 2'h0;
            case (avs_address)
                `DBL_IDX_CTRL: begin
                    avs_readdata <= {24'h000000, dma_burst_link_control_q};
                end
                `DBL_IDX_MODE: begin
                    avs_readdata <= {30'h00000000, if_mode};
                end
                `DBL_IDX_BASE: begin
                    avs_readdata <= {29'h00000000, io_base_select};
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                    avs_response <= 2'h2;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/dbl_props.sv
// Checker for the burst / link-test register.
// Bound to dbl_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dbl_props (
    input wire logic mclk, srst, avs_read, avs_write, avs_waitrequest, io_rd, link_test_run,
    input wire logic [3:0] avs_address, avs_byteenable,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [1:0] avs_response, if_mode,
    input wire logic [4:0] io_offset, dma_burst_count,
    input wire logic [2:0] io_base_select
);
    // Shadow of the control byte, kept from accepted writes
    logic [7:0] shd_q;
    wire wtk = avs_write & ~avs_waitrequest & avs_address == 4'h0 & avs_byteenable[0];
    wire rtk = avs_read & ~avs_waitrequest;
    wire stp = io_rd & io_offset == 5'h12 & if_mode == 2'h1 & shd_q[7];
    always_ff @(posedge mclk) begin
        shd_q <= srst ? 8'h80 : wtk ? avs_writedata[7:0] & 8'hA3 : shd_q;
    end
    // Card mode or code 0 gives one transfer
    function automatic logic [4:0] bcnt(input logic [1:0] c, m);
        return (m == 2'h0 || c == 2'h0) ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h12 : 5'h0C;
    endfunction
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    chk_sel_step: assert property (stp |=> io_base_select == $past(io_base_select) + 3'h1)
        else $error("select not stepped");
    chk_sel_hold: assert property (!stp |=> $stable(io_base_select))
        else $error("select moved");
    // Outputs lag the register by one edge
    chk_link_map: assert property (!$past(wtk) |-> link_test_run == !shd_q[5])
        else $error("link run wrong");
    chk_burst_map: assert property (!$past(wtk) && $stable(if_mode) |->
        dma_burst_count == bcnt(shd_q[1:0], if_mode)) else $error("burst count wrong");
    chk_ctrl_read: assert property (rtk && avs_address == 4'h0 |-> avs_readdata[7:0] == shd_q)
        else $error("readback wrong");
    chk_bad_read: assert property (rtk && avs_address > 4'h2 |-> avs_response == 2'h2)
        else $error("no error response");
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state");
endmodule
bind dbl_ctrl dbl_props u_chk (.*);
`default_nettype wire

// file: tb/dbl_host_io.sv
// Host I/O model: one-cycle read strobes with offset.
// Offset is not held outside a strobe.
`timescale 1ns/1ps
`default_nettype none
module dbl_host_io (
    input wire logic mclk,
    input wire logic go,
    input wire logic [4:0] ofs,
    output var logic io_rd = 1'b0,
    output var logic [4:0] io_offset = 5'h00
);
    always_ff @(posedge mclk) begin
        io_rd <= go;
        io_offset <= go ? ofs : ~io_offset;
    end
endmodule
`default_nettype wire

// file: tb/tb_dbl_ctrl.sv
// Bench for the burst / link-test register.
// Drives the bus and the host I/O model from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb_dbl_ctrl;
    logic mclk = 0, srst = 1, avs_read = 0, avs_write = 0, go = 0, unl = 1;
    logic avs_waitrequest, link_test_run, io_rd;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat, seed = 32'hBC61;
    logic [1:0] avs_response, rsp, if_mode = 2'h0;
    logic [4:0] ofs = 5'h00, io_offset, dma_burst_count;
    logic [2:0] io_base_select, sel_m = 3'h0;
    logic [7:0] d;
    int n_errors = 0, num_checks = 0;
    always #4 mclk = ~mclk;
    dbl_ctrl uut (.avs_byteenable(4'hF), .*);
    dbl_host_io host (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] ecnt(input logic [1:0] c, m);
        return (m == 2'h0 || c == 2'h0) ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h12 : 5'h0C;
    endfunction
    task automatic chk(input logic [33:0] g, e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hold the request until waitrequest is seen low
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
        int k = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, v};
        @(posedge mclk);
        // Waitrequest and read data are seen as they stood before this edge
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            k++;
            @(posedge mclk);
        end
        if (k >= 50) n_errors++;
        rdat = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // One idle edge so the next call never re-raises in this time step
        @(posedge mclk);
    endtask
    // One host read strobe, then compare the select
    task automatic io(input logic [4:0] o);
        go <= 1'b1;
        ofs <= o;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        if (o == 5'h12 && if_mode == 2'h1 && unl) sel_m++;
        @(negedge mclk);
        chk(io_base_select, sel_m);
        @(posedge mclk);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        acc(0, 4'h0, 8'h00);
        chk(rdat, 32'h80);
        chk({link_test_run, dma_burst_count}, 6'h21);
        // Every code in every mode, link bit random
        for (int i = 0; i < 16; i++) begin
            d = 8'(rnd()) & 8'hA3;
            d[1:0] = i[1:0];
            d[7] = i[0];
            if_mode <= i[3:2];
            acc(1, 4'h0, d);
            unl = d[7];
            acc(0, 4'h0, 8'h00);
            chk(rdat, {24'h0, d & 8'hA3});
            chk(link_test_run, !d[5]);
            chk(dma_burst_count, ecnt(d[1:0], i[3:2]));
            repeat (4) io(rnd() % 2 ? 5'h12 : 5'(rnd()));
        end
        acc(0, 4'hF, 8'h00);
        chk({rsp, rdat}, {2'h2, 32'h0});
        conclude();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
